// ### rtc_flags_cfg.svh
// constants for the clock flag and control register
`ifndef RTC_FLAGS_CFG_SVH
`define RTC_FLAGS_CFG_SVH

// register location in the memory-mapped port
`define FLAGS_ADDR 15'h7FF0
`define ADDR_W 15

// bit positions inside the flag register
`define OSC_FAIL_BIT 4
`define CAL_BIT 2
`define HOLD_BIT 1

// reset values
`define CAL_RESET 1'h0
`define HOLD_RESET 1'h0
`define FAIL_RESET 1'h0

// power-up oscillator watch window
`define CLK_FREQ_MHZ 100
`define OSC_WATCH_MS 5
`define OSC_WATCH_CYCLES (`OSC_WATCH_MS * 1000 * `CLK_FREQ_MHZ)
`define WATCH_CNT_W 20

// calibration square wave from the 32768 Hz oscillator
`define OSC_FREQ_HZ 32768
`define CAL_FREQ_HZ 512
`define CAL_HALF_TICKS (`OSC_FREQ_HZ / (2 * `CAL_FREQ_HZ))
`define CAL_DIV_W 5

`endif

// ### rtc_flags_pkg.sv
// types shared by the clock flag and control logic
package rtc_flags_pkg;

  typedef enum logic [1:0] {
    PH_RESTORE,
    PH_WATCH,
    PH_RUN
  } phase_t;

endpackage : rtc_flags_pkg

// ### rtc_flag_control_bits.sv
// clock flag register: oscillator fail flag, calibration output, write hold
//
// Summary of operation
// - with osc_enable high, no oscillator edge in the 5 ms after power-up sets fail
// - fail flag cleared only by software writing 0
// - fail flag kept across power cycles
// - calibration bit puts 512 Hz on interrupt pin
`timescale 1ns/1ps
`include "rtc_flags_cfg.svh"

module rtc_flag_control_bits
  import rtc_flags_pkg::*;
#(
  parameter int WATCH_CYCLES = `OSC_WATCH_CYCLES,
  parameter int TIME_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic osc_clk_in,
  input wire logic osc_enable,
  input wire logic nv_fail_in,
  output logic nv_fail_out,
  input wire logic irq_request,
  input wire logic int_in,
  output logic int_out,
  output logic int_oe_n,
  input wire logic [TIME_W-1:0] user_time,
  output logic counter_load,
  output logic [TIME_W-1:0] counter_load_data
);

  typedef struct packed {
    phase_t phase;
    logic [`WATCH_CNT_W-1:0] watch_cnt;
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic osc_fail;
    logic cal;
    logic hold;
    logic [`CAL_DIV_W-1:0] div;
    logic wave;
    logic pin_oe_n;
    logic [7:0] rdata;
    logic rvalid;
    logic load;
    logic [TIME_W-1:0] load_data;
  } state_t;

  state_t s;
  state_t next_s;

  logic tick;
  logic flags_wr;
  logic clear_fail;
  logic set_fail;
  logic watch_end;

  // pad input is not sampled; the pin is only ever pulled low here
  logic unused_int_in;
  assign unused_int_in = int_in;

  assign tick = s.osc_s2 & ~s.osc_prev;
  assign flags_wr = reg_sel & reg_wr & (reg_addr == `FLAGS_ADDR);
  assign clear_fail = flags_wr & ~reg_wdata[`OSC_FAIL_BIT];
  assign watch_end = (s.phase == PH_WATCH) & ~tick
                     & (s.watch_cnt == `WATCH_CNT_W'(WATCH_CYCLES - 1));
  assign set_fail = watch_end & osc_enable;

  always_comb begin
    next_s = s;
    next_s.osc_s1 = osc_clk_in;
    next_s.osc_s2 = s.osc_s1;
    next_s.osc_prev = s.osc_s2;
    next_s.load = 1'h0;
    next_s.rvalid = 1'h0;

    // power-up sequencing of the oscillator check
    case (s.phase)
      PH_RESTORE: begin
        next_s.phase = PH_WATCH;
        next_s.watch_cnt = '0;
      end
      PH_WATCH: begin
        if (tick || watch_end) begin
          next_s.phase = PH_RUN;
        end else begin
          next_s.watch_cnt = s.watch_cnt + `WATCH_CNT_W'(1);
        end
      end
      PH_RUN: begin
        next_s.phase = PH_RUN;
      end
      default: begin
        next_s.phase = PH_RESTORE;
      end
    endcase

    // fail flag: restore first, then hardware set wins over software clear
    if (s.phase == PH_RESTORE) begin
      next_s.osc_fail = nv_fail_in;
    end else if (set_fail) begin
      next_s.osc_fail = 1'h1;
    end else if (clear_fail) begin
      next_s.osc_fail = 1'h0;
    end

    if (flags_wr) begin
      next_s.cal = reg_wdata[`CAL_BIT];
      next_s.hold = reg_wdata[`HOLD_BIT];
      if (s.hold && !reg_wdata[`HOLD_BIT]) begin
        next_s.load = 1'h1;
        next_s.load_data = user_time;
      end
    end

    // 512 Hz wave: toggle every half period of oscillator ticks
    if (s.cal) begin
      if (tick) begin
        next_s.div = s.div + `CAL_DIV_W'(1);
        if (s.div == `CAL_DIV_W'(`CAL_HALF_TICKS - 1)) begin
          next_s.wave = ~s.wave;
        end
      end
    end else begin
      next_s.div = '0;
      next_s.wave = 1'h0;
    end

    // open drain pin: low drive from wave or normal interrupt
    if (s.cal) begin
      next_s.pin_oe_n = s.wave;
    end else begin
      next_s.pin_oe_n = ~irq_request;
    end

    if (reg_sel && reg_rd) begin
      next_s.rvalid = 1'h1;
      next_s.rdata = 8'h00;
      if (reg_addr == `FLAGS_ADDR) begin
        next_s.rdata[`OSC_FAIL_BIT] = s.osc_fail;
        next_s.rdata[`CAL_BIT] = s.cal;
        next_s.rdata[`HOLD_BIT] = s.hold;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s.phase <= PH_RESTORE;
      s.watch_cnt <= '0;
      s.osc_s1 <= 1'h0;
      s.osc_s2 <= 1'h0;
      s.osc_prev <= 1'h0;
      s.osc_fail <= `FAIL_RESET;
      s.cal <= `CAL_RESET;
      s.hold <= `HOLD_RESET;
      s.div <= '0;
      s.wave <= 1'h0;
      s.pin_oe_n <= 1'h1;
      s.rdata <= 8'h00;
      s.rvalid <= 1'h0;
      s.load <= 1'h0;
      s.load_data <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign nv_fail_out = s.osc_fail;
  assign int_out = 1'h0;
  assign int_oe_n = s.pin_oe_n;
  assign counter_load = s.load;
  assign counter_load_data = s.load_data;

  // checks

  sequence hold_release_s;
    flags_wr && s.hold && !reg_wdata[`HOLD_BIT];
  endsequence

  sequence hold_kept_s;
    s.hold && !(flags_wr && !reg_wdata[`HOLD_BIT]);
  endsequence

  watch_sets_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
    (watch_end && osc_enable) |=> (s.osc_fail && s.phase == PH_RUN))
    else $error("fail flag not set after silent watch window");

  running_osc_ok_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.phase == PH_WATCH && tick && !s.osc_fail && !flags_wr) |=> !s.osc_fail)
    else $error("fail flag set although oscillator ran");

  no_self_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.osc_fail && s.phase != PH_RESTORE && !clear_fail) |=> s.osc_fail)
    else $error("fail flag cleared without software write");

  restore_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.phase == PH_RESTORE) |=> (s.osc_fail == $past(nv_fail_in)) && nv_fail_out == s.osc_fail)
    else $error("fail flag not restored after power up");

  cal_wave_toggle_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.cal && tick && s.div == `CAL_DIV_W'(`CAL_HALF_TICKS - 1)) |=> s.wave != $past(s.wave))
    else $error("calibration wave did not toggle");

  cal_pin_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
    (s.cal && !s.wave) |=> !int_oe_n)
    else $error("interrupt pin not pulled low by calibration wave");

  hold_release_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    hold_release_s |=> counter_load && counter_load_data == $past(user_time))
    else $error("counters not loaded when write hold released");

  hold_blocks_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    hold_kept_s |=> !counter_load)
    else $error("counter load while write hold set");

endmodule : rtc_flag_control_bits

// ### rtc_flag_control_bits_tb.sv
// testbench for the clock flag and control register
`timescale 1ns/1ps
`include "rtc_flags_cfg.svh"

module rtc_flag_control_bits_tb;
  logic clk = 0, arst_n = 0, sel = 0, wr = 0, rd = 0, osc = 0, irq = 0, nv_in = 0;
  logic osc_en = 1;
  logic [`ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = '0, rdata, ut = '0, ld_data;
  logic rvalid, nv_out, int_out, int_oe_n, ld;
  int failures = 0, total_checks = 0;
  // address, write data, expected read-back
  logic [30:0] rows [4] = '{{`FLAGS_ADDR, 8'h06, 8'h06}, {`FLAGS_ADDR, 8'hFF, 8'h06},
    {15'h7FF1, 8'h00, 8'h06}, {`FLAGS_ADDR, 8'h00, 8'h00}};

  rtc_flag_control_bits #(.WATCH_CYCLES(50), .TIME_W(8)) dut (.clk(clk), .arst_n(arst_n),
    .reg_sel(sel), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .osc_clk_in(osc), .osc_enable(osc_en),
    .nv_fail_in(nv_in), .nv_fail_out(nv_out), .irq_request(irq), .int_in(int_oe_n),
    .int_out(int_out), .int_oe_n(int_oe_n), .user_time(ut), .counter_load(ld),
    .counter_load_data(ld_data));

  initial begin
    forever #5 clk = ~clk;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [14:0] a, input logic [7:0] d);
    tick(1);
    sel = 1; wr = 1; addr = a; wdata = d;
    tick(1);
    sel = 0; wr = 0;
  endtask : wr_reg

  task rd_reg(input logic [14:0] a, input logic [7:0] e);
    tick(1);
    sel = 1; rd = 1; addr = a;
    tick(1);
    sel = 0; rd = 0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask : rd_reg

  // osc rises every 4 clock cycles
  task pulse(input int n);
    repeat (n) begin
      osc = 1; tick(2); osc = 0; tick(2);
    end
  endtask : pulse

  task rst(input logic nv);
    arst_n = 0; nv_in = nv;
    tick(2);
    chk({6'h00, nv_out, int_oe_n}, 8'h01);
    arst_n = 1;
  endtask : rst

  task close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  initial begin
    #100000;
    failures++;
    close_out();
  end

  initial begin
    rst(1'b0);
    tick(60);
    rd_reg(`FLAGS_ADDR, 8'h10);
    chk({7'h00, nv_out}, 8'h01);
    wr_reg(`FLAGS_ADDR, 8'h10);
    rd_reg(`FLAGS_ADDR, 8'h10);
    wr_reg(`FLAGS_ADDR, 8'h00);
    rd_reg(`FLAGS_ADDR, 8'h00);
    $display("test fail flag set and clear done");
    rst(1'b1);
    tick(1);
    chk({7'h00, nv_out}, 8'h01);
    pulse(3);
    tick(60);
    rd_reg(`FLAGS_ADDR, 8'h10);
    wr_reg(`FLAGS_ADDR, 8'h00);
    rst(1'b0);
    pulse(3);
    tick(60);
    rd_reg(`FLAGS_ADDR, 8'h00);
    $display("test power cycle done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(rows[i][30:16], rows[i][15:8]);
      rd_reg(`FLAGS_ADDR, rows[i][7:0]);
    end
    rd_reg(15'h7FF1, 8'h00);
    $display("test register rows done");
    wr_reg(`FLAGS_ADDR, 8'h02);
    ut = 8'hA5;
    wr_reg(`FLAGS_ADDR, 8'h02);
    chk({7'h00, ld}, 8'h00);
    wr_reg(`FLAGS_ADDR, 8'h00);
    chk({7'h00, ld}, 8'h01);
    chk(ld_data, 8'hA5);
    $display("test write hold done");
    wr_reg(`FLAGS_ADDR, 8'h04);
    tick(1);
    chk({7'h00, int_oe_n}, 8'h00);
    pulse(31);
    tick(2);
    chk({7'h00, int_oe_n}, 8'h00);
    pulse(1);
    tick(4);
    chk({7'h00, int_oe_n}, 8'h01);
    wr_reg(`FLAGS_ADDR, 8'h00);
    irq = 1;
    tick(2);
    chk({6'h00, int_out, int_oe_n}, 8'h00);
    irq = 0;
    tick(2);
    chk({7'h00, int_oe_n}, 8'h01);
    wr_reg(`FLAGS_ADDR, 8'h06);
    rst(1'b0);
    rd_reg(`FLAGS_ADDR, 8'h00);
    $display("test calibration output done");
    osc_en = 0;
    rst(1'b0);
    tick(60);
    rd_reg(`FLAGS_ADDR, 8'h00);
    osc_en = 1;
    rst(1'b0);
    // clear lands on the edge that ends the silent window
    tick(49);
    wr_reg(`FLAGS_ADDR, 8'h00);
    rd_reg(`FLAGS_ADDR, 8'h10);
    $display("test enable and set over clear done");
    close_out();
  end
endmodule : rtc_flag_control_bits_tb
